// ---- shared/vts_pkg.sv ----
// Constants, types and register map of the video RAM transfer and serial port controller
// Contract
// - Transfer-select is low before row strobe falls; write, gate and special inputs sampled there.
// - Controller presents valid 9-bit tap address when column strobe falls, only when changing.
// - Only a read transfer returns the serial port from write mode to read mode.
// - After power-up wait 200 us, eight refreshes, one read transfer, two shift clocks.
package vts_pkg;
	// ----------------------------------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ROW = 8'h04;
	localparam logic [7:0] REG_TAP = 8'h08;
	localparam logic [7:0] REG_SHIFT = 8'h0c;
	localparam logic [7:0] REG_CFG = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_LOADTAP_BIT = 3;
	localparam int CFG_GATE_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_INITDONE_BIT = 1;
	localparam int ST_WMODE_BIT = 2;
	localparam int ST_RDATA_LSB = 4;
	localparam int ST_POS_LSB = 16;

	// ----------------------------------------------------------------
	// Cycle kinds
	// ----------------------------------------------------------------
	localparam logic [2:0] KIND_REFRESH = 3'h0;
	localparam logic [2:0] KIND_READ = 3'h1;
	localparam logic [2:0] KIND_WRITE = 3'h2;
	localparam logic [2:0] KIND_ALTWRITE = 3'h3;
	localparam logic [2:0] KIND_PSEUDO = 3'h4;

	// ----------------------------------------------------------------
	// Widths, reset values and timing
	// ----------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam int DATA_W = 4;
	localparam logic [8:0] ROW_RESET = 9'h000;
	localparam logic [8:0] TAP_RESET = 9'h000;
	localparam logic CFG_GATE_RESET = 1'b0;
	localparam int CLK_PERIOD_NS = 100;
	localparam int INIT_WAIT_US = 200;
	localparam int INIT_WAIT_CYCLES = (INIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] INIT_WAIT_CNT = 12'(INIT_WAIT_CYCLES);
	localparam logic [3:0] INIT_REFRESHES = 4'h8;
	localparam logic [1:0] INIT_SHIFTS = 2'h2;
	localparam logic [1:0] SC_HALF_LAST = 2'h1;

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_RASLOW, S_COLADDR, S_CASLOW, S_TRGHIGH,
		S_RASHIGH} vts_seq_t;

	typedef struct packed {
		logic rowStrobeN;
		logic colStrobeN;
		logic transferSelectN;
		logic writeN;
		logic shiftPortGateN;
		logic altFunctionIn;
		logic [8:0] muxAddrPins;
	} vts_strobe_t;
endpackage

// ---- rtl/vts_shift_engine.sv ----
// Shift clock generator and serial data port for the video RAM serial side
`timescale 1ns/100ps
`default_nettype none
module vts_shift_engine (
	input wire logic core_clk, // System clock
	input wire logic rst_n, // Synchronous reset
	input wire logic start, // Request one shift clock pulse
	input wire logic [3:0] wrData, // Nibble to drive in write mode
	input wire logic driveData, // Drive the data pins
	input wire logic [3:0] dataIn, // Serial pins, raw
	output logic shiftClock, // Shift clock pin
	output logic [3:0] dataOut, // Serial pins out
	output logic dataOe, // Serial pins enable
	output logic busy, // Pulse in progress
	output logic done, // Pulse finished
	output logic [3:0] rdData // Nibble sampled at pulse end
);
	logic [3:0] syncA;
	logic [3:0] syncB;
	logic [1:0] halfCntQ;
	logic phaseQ;
	logic tick;

	// ----------------------------------------------------------------
	// Input synchroniser and half period divider
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			syncA <= 4'h0;
			syncB <= 4'h0;
		end
		else
		begin
			syncA <= dataIn;
			syncB <= syncA;
		end
	end

	assign tick = busy && (halfCntQ == vts_pkg::SC_HALF_LAST);

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !busy || tick)
			halfCntQ <= 2'h0;
		else
			halfCntQ <= halfCntQ + 2'h1;
	end

	// ----------------------------------------------------------------
	// Pulse sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			phaseQ <= 1'b0;
			shiftClock <= 1'b0;
			done <= 1'b0;
			dataOut <= 4'h0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				busy <= 1'b1;
				phaseQ <= 1'b0;
				dataOut <= wrData;
			end
			else if (tick && !phaseQ)
			begin
				shiftClock <= 1'b1;
				phaseQ <= 1'b1;
			end
			else if (tick)
			begin
				shiftClock <= 1'b0;
				phaseQ <= 1'b0;
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end

	// Capture one cycle after the pulse so the synchroniser holds the new bit
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rdData <= 4'h0;
		else if (done)
			rdData <= syncB;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			dataOe <= 1'b0;
		else
			dataOe <= driveData;
	end
endmodule
`default_nettype wire

// ---- rtl/vts_host_ctrl.sv ----
// AHB-Lite controlled host for video RAM transfer cycles and serial port
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module vts_host_ctrl (
	input wire logic core_clk, // System clock, 10 MHz
	input wire logic rst_n, // Synchronous reset
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB ready in
	output logic hreadyout, // AHB ready out
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // AHB response
	output var vts_pkg::vts_strobe_t strobes, // Strobes and address pins
	output logic shiftClock, // Shift clock pin
	input wire logic [3:0] shiftPortDataIn, // Serial pins in
	output logic [3:0] shiftPortDataOut, // Serial pins out
	output logic shiftPortDataOe // Serial pins enable
);
	vts_pkg::vts_seq_t stateQ;
	logic [2:0] kindQ;
	logic loadTapQ;
	logic [8:0] rowQ;
	logic [8:0] tapRegQ;
	logic [8:0] tapUsedQ;
	logic [8:0] posQ;
	logic gateEnQ;
	logic serialWriteQ;
	logic [3:0] shiftDataQ;
	logic [11:0] waitCntQ;
	logic [3:0] initRefQ;
	logic initReadQ;
	logic [1:0] initShiftQ;
	logic initDoneQ;
	logic wrPendQ;
	logic [7:0] wrAddrQ;
	logic waitDone;
	logic seqBusy;
	logic engBusy;
	logic engDone;
	logic [3:0] engRdata;
	logic launch;
	logic [2:0] launchKind;
	logic launchTap;
	logic shiftStart;
	logic swCmd;
	logic swShift;
	logic [3:0] engWrData;

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wrPendQ <= 1'b0;
			wrAddrQ <= 8'h00;
		end
		else
		begin
			wrPendQ <= hsel && htrans[1] && hready && hwrite;
			wrAddrQ <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite)
			begin
				hrdata <= 32'h0000_0000;
				case (haddr[7:0])
					vts_pkg::REG_CMD: hrdata[3:0] <= {loadTapQ, kindQ};
					vts_pkg::REG_ROW: hrdata[8:0] <= rowQ;
					vts_pkg::REG_TAP: hrdata[8:0] <= tapRegQ;
					vts_pkg::REG_SHIFT: hrdata[3:0] <= shiftDataQ;
					vts_pkg::REG_CFG: hrdata[vts_pkg::CFG_GATE_BIT] <= gateEnQ;
					vts_pkg::REG_STATUS:
					begin
						hrdata[vts_pkg::ST_BUSY_BIT] <= seqBusy || engBusy || !initDoneQ;
						hrdata[vts_pkg::ST_INITDONE_BIT] <= initDoneQ;
						hrdata[vts_pkg::ST_WMODE_BIT] <= serialWriteQ;
						hrdata[vts_pkg::ST_RDATA_LSB +: 4] <= engRdata;
						hrdata[vts_pkg::ST_POS_LSB +: 9] <= posQ;
					end
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign seqBusy = (stateQ != vts_pkg::S_IDLE);
	assign swCmd = wrPendQ && (wrAddrQ == vts_pkg::REG_CMD);
	assign swShift = wrPendQ && (wrAddrQ == vts_pkg::REG_SHIFT);
	// Shift data register updates on the launching edge, so bypass it then
	assign engWrData = swShift ? hwdata[3:0] : shiftDataQ;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rowQ <= vts_pkg::ROW_RESET;
			tapRegQ <= vts_pkg::TAP_RESET;
			gateEnQ <= vts_pkg::CFG_GATE_RESET;
			shiftDataQ <= 4'h0;
		end
		else if (wrPendQ)
		begin
			case (wrAddrQ)
				vts_pkg::REG_ROW: rowQ <= hwdata[8:0];
				vts_pkg::REG_TAP: tapRegQ <= hwdata[8:0];
				vts_pkg::REG_CFG: gateEnQ <= hwdata[vts_pkg::CFG_GATE_BIT];
				vts_pkg::REG_SHIFT: shiftDataQ <= hwdata[3:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Power-up sequence and launch selection
	// ----------------------------------------------------------------
	assign waitDone = (waitCntQ == vts_pkg::INIT_WAIT_CNT);

	always_comb
	begin
		launch = 1'b0;
		launchKind = vts_pkg::KIND_REFRESH;
		launchTap = 1'b0;
		shiftStart = 1'b0;
		if (!initDoneQ)
		begin
			if (waitDone && !seqBusy && !engBusy)
			begin
				if (initRefQ != vts_pkg::INIT_REFRESHES)
					launch = 1'b1;
				else if (!initReadQ)
				begin
					launch = 1'b1;
					launchKind = vts_pkg::KIND_READ;
				end
				else if (initShiftQ != vts_pkg::INIT_SHIFTS)
					shiftStart = 1'b1;
			end
		end
		else if (!seqBusy && !engBusy)
		begin
			launch = swCmd;
			launchKind = hwdata[vts_pkg::CMD_KIND_LSB +: 3];
			launchTap = hwdata[vts_pkg::CMD_LOADTAP_BIT];
			shiftStart = swShift;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			waitCntQ <= 12'h000;
			initRefQ <= 4'h0;
			initReadQ <= 1'b0;
			initShiftQ <= 2'h0;
			initDoneQ <= 1'b0;
		end
		else if (!initDoneQ)
		begin
			if (!waitDone)
				waitCntQ <= waitCntQ + 12'h001;
			if (launch && launchKind == vts_pkg::KIND_REFRESH)
				initRefQ <= initRefQ + 4'h1;
			if (launch && launchKind == vts_pkg::KIND_READ)
				initReadQ <= 1'b1;
			if (shiftStart)
				initShiftQ <= initShiftQ + 2'h1;
			if (initShiftQ == vts_pkg::INIT_SHIFTS && !engBusy && !seqBusy)
				initDoneQ <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Transfer and refresh cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			stateQ <= vts_pkg::S_IDLE;
			kindQ <= vts_pkg::KIND_REFRESH;
			loadTapQ <= 1'b0;
			strobes <= '{rowStrobeN: 1'b1, colStrobeN: 1'b1, transferSelectN: 1'b1,
				writeN: 1'b1, shiftPortGateN: 1'b1, altFunctionIn: 1'b0, muxAddrPins: 9'h000};
		end
		else
		begin
			case (stateQ)
				vts_pkg::S_IDLE:
				begin
					strobes.shiftPortGateN <= !gateEnQ;
					if (launch)
					begin
						kindQ <= launchKind;
						loadTapQ <= launchTap && (launchKind != vts_pkg::KIND_REFRESH);
						strobes.transferSelectN <= (launchKind == vts_pkg::KIND_REFRESH);
						strobes.writeN <= (launchKind == vts_pkg::KIND_READ)
							|| (launchKind == vts_pkg::KIND_REFRESH);
						strobes.altFunctionIn <= (launchKind == vts_pkg::KIND_ALTWRITE);
						if (launchKind == vts_pkg::KIND_PSEUDO)
							strobes.shiftPortGateN <= 1'b1;
						else if (launchKind == vts_pkg::KIND_WRITE)
							strobes.shiftPortGateN <= 1'b0;
						strobes.muxAddrPins <= rowQ;
						stateQ <= vts_pkg::S_SETUP;
					end
				end
				vts_pkg::S_SETUP:
				begin
					strobes.rowStrobeN <= 1'b0;
					stateQ <= vts_pkg::S_RASLOW;
				end
				vts_pkg::S_RASLOW:
				begin
					strobes.muxAddrPins <= tapRegQ;
					stateQ <= vts_pkg::S_COLADDR;
				end
				vts_pkg::S_COLADDR:
				begin
					strobes.colStrobeN <= !loadTapQ;
					stateQ <= vts_pkg::S_CASLOW;
				end
				vts_pkg::S_CASLOW:
				begin
					strobes.transferSelectN <= 1'b1;
					stateQ <= vts_pkg::S_TRGHIGH;
				end
				vts_pkg::S_TRGHIGH:
				begin
					strobes.rowStrobeN <= 1'b1;
					strobes.colStrobeN <= 1'b1;
					stateQ <= vts_pkg::S_RASHIGH;
				end
				vts_pkg::S_RASHIGH:
				begin
					strobes.writeN <= 1'b1;
					strobes.altFunctionIn <= 1'b0;
					strobes.shiftPortGateN <= !gateEnQ;
					stateQ <= vts_pkg::S_IDLE;
				end
				default: stateQ <= vts_pkg::S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mirror of tap, serial mode and serial position
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			tapUsedQ <= vts_pkg::TAP_RESET;
			serialWriteQ <= 1'b0;
			posQ <= 9'h000;
		end
		else
		begin
			if (stateQ == vts_pkg::S_COLADDR && loadTapQ)
				tapUsedQ <= tapRegQ;
			if (stateQ == vts_pkg::S_TRGHIGH && kindQ == vts_pkg::KIND_READ)
			begin
				serialWriteQ <= 1'b0;
				posQ <= tapUsedQ;
			end
			else if (stateQ == vts_pkg::S_TRGHIGH && kindQ == vts_pkg::KIND_PSEUDO)
				serialWriteQ <= 1'b1;
			else if (engDone)
				posQ <= posQ + 9'h001;
		end
	end

	vts_shift_engine u_shift (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(shiftStart),
		.wrData(engWrData),
		.driveData(serialWriteQ && gateEnQ && !seqBusy),
		.dataIn(shiftPortDataIn),
		.shiftClock(shiftClock),
		.dataOut(shiftPortDataOut),
		.dataOe(shiftPortDataOe),
		.busy(engBusy),
		.done(engDone),
		.rdData(engRdata)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_trg_before_ras;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(strobes.rowStrobeN) && !strobes.transferSelectN
			|-> $past(strobes.transferSelectN) == 1'b0 && $stable(strobes.writeN)
			&& $stable(strobes.altFunctionIn) && $stable(strobes.shiftPortGateN);
	endproperty
	a_trg_before_ras: assert property (p_trg_before_ras) else $error("transfer select late");

	property p_tap_addr;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(strobes.colStrobeN) |-> strobes.muxAddrPins == tapUsedQ
			&& $past(strobes.muxAddrPins) == strobes.muxAddrPins;
	endproperty
	a_tap_addr: assert property (p_tap_addr) else $error("tap address not valid");

	property p_read_mode_return;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(serialWriteQ) |-> $past(kindQ) == vts_pkg::KIND_READ
			&& $past(stateQ) == vts_pkg::S_TRGHIGH;
	endproperty
	a_read_mode_return: assert property (p_read_mode_return) else $error("bad mode exit");

	property p_no_early_ras;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(strobes.rowStrobeN) |-> waitCntQ == vts_pkg::INIT_WAIT_CNT;
	endproperty
	a_no_early_ras: assert property (p_no_early_ras) else $error("row strobe before wait");

	property p_init_complete;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(initDoneQ) |-> initRefQ == vts_pkg::INIT_REFRESHES && initReadQ
			&& initShiftQ == vts_pkg::INIT_SHIFTS && !shiftClock;
	endproperty
	a_init_complete: assert property (p_init_complete) else $error("init incomplete");
endmodule
`default_nettype wire

// ---- bench/vts_vram_model.sv ----
// Behavioural video RAM seen from the controller: transfer decode and serial port
`timescale 1ns/100ps
`default_nettype none
module vts_vram_model (
	input wire vts_pkg::vts_strobe_t pins, // Strobes and address pins
	input wire logic shiftClock, // Shift clock pin
	input wire logic [3:0] dataIn, // Resolved serial wire
	output logic [3:0] sqOut, // Serial output value
	output logic sqDrive // Device drives serial pins
);
	logic [3:0] sreg [512];
	logic [8:0] lastRow, tap, pos;
	logic [2:0] lastKind;
	logic inXfer, readMode, pending, altActive;
	int rasOnly, readCnt, scCnt, rowsRefreshed;
	initial
	begin
		for (int i = 0; i < 512; i++)
			sreg[i] = 4'h0;
		{lastRow, tap, pos, sqOut} = '0;
		{inXfer, readMode, pending, altActive} = '0;
		lastKind = 3'h7;
		{rasOnly, readCnt, scCnt, rowsRefreshed} = '0;
	end
	// ----------------------------------------------------------------
	// Cycle decode at row strobe fall
	// ----------------------------------------------------------------
	always @(negedge pins.rowStrobeN)
	begin
		lastRow = pins.muxAddrPins;
		if (!pins.colStrobeN)
			rasOnly++;
		else if (!pins.transferSelectN)
		begin
			inXfer = 1'b1;
			if (pins.writeN)
				lastKind = vts_pkg::KIND_READ;
			else if (pins.altFunctionIn)
			begin
				lastKind = vts_pkg::KIND_ALTWRITE;
				altActive = 1'b1;
			end
			else if (!pins.shiftPortGateN)
				lastKind = vts_pkg::KIND_WRITE;
			else
			begin
				lastKind = vts_pkg::KIND_PSEUDO;
				readMode = 1'b0;
			end
			if (lastKind == vts_pkg::KIND_READ || lastKind == vts_pkg::KIND_PSEUDO)
				rowsRefreshed++;
		end
		else
		begin
			lastKind = vts_pkg::KIND_REFRESH;
			rasOnly++;
		end
	end
	always @(negedge pins.colStrobeN)
		if (inXfer && !pins.rowStrobeN)
			tap = pins.muxAddrPins;
	// Row lands in the register as transfer select returns high
	always @(posedge pins.transferSelectN)
		if (inXfer && lastKind == vts_pkg::KIND_READ)
		begin
			for (int i = 0; i < 512; i++)
				sreg[i] = lastRow[3:0] ^ 4'(i) ^ {i[8], 3'b0};
			pending = 1'b1;
			readMode = 1'b1;
			readCnt++;
		end
	always @(posedge pins.rowStrobeN)
	begin
		inXfer = 1'b0;
		altActive = 1'b0;
	end
	// ----------------------------------------------------------------
	// Serial port, event driven so any rate works
	// ----------------------------------------------------------------
	always @(posedge shiftClock)
	begin
		scCnt++;
		if (pending)
		begin
			pos = tap;
			pending = 1'b0;
		end
		else
		begin
			if (!readMode && !pins.shiftPortGateN)
				sreg[pos] = dataIn;
			pos = pos + 9'h1;
		end
		sqOut = sreg[pos];
	end
	assign sqDrive = readMode && !pins.shiftPortGateN && !altActive;
endmodule
`default_nettype wire

// ---- bench/test_video_ram_transfer_serial_port.sv ----
// Self-checking bench for the transfer and serial port controller
`timescale 1ns/100ps
`default_nettype none
module test_video_ram_transfer_serial_port;
	logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, shiftClock, hostOe, devDrive;
	logic [31:0] haddr, hwdata, hrdata, s;
	logic [1:0] htrans;
	logic [3:0] hostOut, devOut;
	wire logic [3:0] sdqWire;
	vts_pkg::vts_strobe_t strobes;
	int num_errors, comparisons, cycles;
	// Undriven wire shows the inverse of the last device value
	assign sdqWire = hostOe ? hostOut : (devDrive ? devOut : ~devOut);
	vts_host_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .strobes(strobes),
		.shiftClock(shiftClock), .shiftPortDataIn(sdqWire), .shiftPortDataOut(hostOut),
		.shiftPortDataOe(hostOe));
	vts_vram_model dev (.pins(strobes), .shiftClock(shiftClock), .dataIn(sdqWire),
		.sqOut(devOut), .sqDrive(devDrive));
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			num_errors++;
			finish_test;
		end
	end
	// ----------------------------------------------------------------
	// Bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, s);
	endtask
	task automatic waitIdle;
		int n;
		n = 0;
		do
		begin
			rd(vts_pkg::REG_STATUS);
			n++;
		end
		while (s[0] !== 1'b0 && n < 100);
		chk({31'h0, s[0]}, 32'h0);
	endtask
	task automatic cmd(input logic [2:0] kind, input logic loadTap);
		wr(vts_pkg::REG_CMD, {28'h0, loadTap, kind});
		waitIdle;
	endtask
	task automatic sh(input logic [3:0] d);
		wr(vts_pkg::REG_SHIFT, {28'h0, d});
		waitIdle;
	endtask
	function automatic logic [3:0] nib(input logic [8:0] r, input logic [8:0] p);
		return r[3:0] ^ p[3:0] ^ {p[8], 3'b0};
	endfunction
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_init;
		int n;
		chk({17'h0, strobes}, 32'h7c00);
		chk({30'h0, shiftClock, hostOe}, 32'h0);
		chk({30'h0, hreadyout, hresp}, 32'h2);
		rd(vts_pkg::REG_STATUS);
		chk({31'h0, s[1]}, 32'h0);
		wr(vts_pkg::REG_CMD, {29'h0, vts_pkg::KIND_PSEUDO});
		n = 0;
		do
		begin
			rd(vts_pkg::REG_STATUS);
			n++;
		end
		while (s[1] !== 1'b1 && n < 1500);
		chk({31'h0, s[1]}, 32'h1);
		chk(32'(dev.rasOnly >= 8), 32'h1);
		chk(32'(dev.readCnt), 32'h1);
		chk(32'(dev.scCnt), 32'h2);
		chk({29'h0, dev.lastKind}, {29'h0, vts_pkg::KIND_READ});
		$display("test init done");
	endtask
	task automatic t_tap;
		logic [3:0] old;
		logic [8:0] p;
		wr(vts_pkg::REG_ROW, 32'h1a5);
		wr(vts_pkg::REG_TAP, 32'h1fe);
		wr(vts_pkg::REG_CFG, 32'h1);
		old = devOut;
		cmd(vts_pkg::KIND_READ, 1'b1);
		chk({29'h0, dev.lastKind}, {29'h0, vts_pkg::KIND_READ});
		chk({23'h0, dev.lastRow}, 32'h1a5);
		chk({23'h0, dev.tap}, 32'h1fe);
		chk({28'h0, devOut}, {28'h0, old});
		chk(32'(dev.rowsRefreshed), 32'h2);
		for (int k = 1; k <= 3; k++)
		begin
			p = 9'h1fe + 9'(k - 1);
			sh(4'h0);
			rd(vts_pkg::REG_STATUS);
			chk({28'h0, s[7:4]}, {28'h0, nib(9'h1a5, p)});
			chk({23'h0, dev.pos}, {23'h0, p});
			chk({23'h0, s[24:16]}, {23'h0, p + 9'h1});
		end
		$display("test tap done");
	endtask
	task automatic t_keep;
		logic [8:0] p;
		wr(vts_pkg::REG_ROW, 32'h3);
		wr(vts_pkg::REG_TAP, 32'h55);
		cmd(vts_pkg::KIND_READ, 1'b0);
		chk({23'h0, dev.tap}, 32'h1fe);
		sh(4'h0);
		rd(vts_pkg::REG_STATUS);
		chk({28'h0, s[7:4]}, {28'h0, nib(9'h3, 9'h1fe)});
		wr(vts_pkg::REG_CFG, 32'h0);
		p = dev.pos;
		sh(4'h0);
		chk({31'h0, devDrive}, 32'h0);
		chk({23'h0, dev.pos}, {23'h0, p + 9'h1});
		$display("test keep done");
	endtask
	task automatic t_write;
		logic [8:0] p;
		logic [3:0] old;
		wr(vts_pkg::REG_CFG, 32'h1);
		cmd(vts_pkg::KIND_PSEUDO, 1'b0);
		chk({29'h0, dev.lastKind}, {29'h0, vts_pkg::KIND_PSEUDO});
		rd(vts_pkg::REG_STATUS);
		chk({31'h0, s[2]}, 32'h1);
		chk({30'h0, hostOe, devDrive}, 32'h2);
		p = dev.pos;
		sh(4'ha);
		chk({28'h0, dev.sreg[p]}, 32'ha);
		wr(vts_pkg::REG_CFG, 32'h0);
		p = dev.pos;
		old = dev.sreg[p];
		sh(4'h5);
		chk({28'h0, dev.sreg[p]}, {28'h0, old});
		$display("test write done");
	endtask
	task automatic t_kinds;
		logic [2:0] kinds [4];
		kinds = '{vts_pkg::KIND_REFRESH, vts_pkg::KIND_WRITE, vts_pkg::KIND_ALTWRITE,
			vts_pkg::KIND_READ};
		wr(vts_pkg::REG_CMD, {29'h0, vts_pkg::KIND_WRITE});
		wr(vts_pkg::REG_CMD, {29'h0, vts_pkg::KIND_ALTWRITE});
		waitIdle;
		chk({29'h0, dev.lastKind}, {29'h0, vts_pkg::KIND_WRITE});
		foreach (kinds[i])
		begin
			cmd(kinds[i], 1'b1);
			chk({29'h0, dev.lastKind}, {29'h0, kinds[i]});
		end
		chk({23'h0, dev.tap}, 32'h55);
		chk({31'h0, dev.readMode}, 32'h1);
		rd(vts_pkg::REG_STATUS);
		chk({31'h0, s[2]}, 32'h0);
		wr(8'h20, 32'hffff);
		rd(8'h20);
		chk(s, 32'h0);
		$display("test kinds done");
	endtask
	task automatic finish_test;
		$display("counts: %0d mismatches, %0d comparisons", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		{rst_n, hsel, hwrite, haddr, hwdata, htrans} = '0;
		{num_errors, comparisons, cycles} = '0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_init;
		t_tap;
		t_keep;
		t_write;
		t_kinds;
		finish_test;
	end
endmodule
`default_nettype wire
